/* File: hw/zdcc_pkg.sv */
// Constants, types and tables for the zero delay clock divider control
package zdcc_pkg;

	localparam int          DIV_W      = 8;
	localparam int          CTRL_W     = 14;
	localparam int          SER_N      = 12;
	localparam int          NPIN       = 8;
	localparam int          NOUT       = 14;
	localparam int          NDIV       = 4;
	localparam int          BANK_N     = 4;
	localparam int          LCM_SEARCH = 20;

	localparam logic [7:0]  ADR_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_MASK   = 8'h04;
	localparam logic [7:0]  ADR_STAT   = 8'h08;

	localparam logic [13:0] CTRL_RST   = 14'h3FFF;
	localparam logic [11:0] MASK_RST   = 12'hFFF;
	localparam logic [7:0]  RATIO_RST  = 8'h04;
	localparam logic [3:0]  SER_LAST   = 4'hB;

	localparam int          PIN_REF_P  = 0;
	localparam int          PIN_REF_N  = 1;
	localparam int          PIN_T1     = 2;
	localparam int          PIN_T2     = 3;
	localparam int          PIN_FBIN   = 4;
	localparam int          PIN_MR     = 5;
	localparam int          PIN_SCLK   = 6;
	localparam int          PIN_SDAT   = 7;

	localparam int          DIV_A      = 0;
	localparam int          DIV_B      = 1;
	localparam int          DIV_C      = 2;
	localparam int          DIV_FB     = 3;

	localparam int          OUT_C3     = 11;
	localparam int          OUT_C2     = 10;
	localparam int          OUT_FB     = 12;
	localparam int          OUT_SYNC   = 13;

	typedef struct packed {
		logic       bank_c_invert_select;
		logic [1:0] bank_c_divider_select;
		logic [1:0] bank_b_divider_select;
		logic [1:0] bank_a_divider_select;
		logic [2:0] feedback_multiplier_select;
		logic       vco_halve_select;
		logic       test_clock_select;
		logic       reference_select;
		logic       pll_enable;
	} zdcc_ctrl_t;

	typedef enum logic {SER_IDLE, SER_SHIFT} zdcc_ser_state_t;

	// Ratios after the halving stage
	function automatic logic [7:0] fb_ratio(input logic [2:0] s);
		unique case (s)
			3'h0: return 8'h04;
			3'h1: return 8'h06;
			3'h2: return 8'h08;
			3'h3: return 8'h0A;
			3'h4: return 8'h08;
			3'h5: return 8'h0C;
			3'h6: return 8'h10;
			3'h7: return 8'h14;
		endcase
	endfunction : fb_ratio

	function automatic logic [7:0] a_ratio(input logic [1:0] s);
		unique case (s)
			2'h0: return 8'h04;
			2'h1: return 8'h06;
			2'h2: return 8'h08;
			2'h3: return 8'h0C;
		endcase
	endfunction : a_ratio

	function automatic logic [7:0] b_ratio(input logic [1:0] s);
		unique case (s)
			2'h0: return 8'h04;
			2'h1: return 8'h06;
			2'h2: return 8'h08;
			2'h3: return 8'h0A;
		endcase
	endfunction : b_ratio

	function automatic logic [7:0] c_ratio(input logic [1:0] s);
		unique case (s)
			2'h0: return 8'h02;
			2'h1: return 8'h04;
			2'h2: return 8'h06;
			2'h3: return 8'h08;
		endcase
	endfunction : c_ratio

	function automatic logic [7:0] lcm2(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] m;
		logic [7:0]  res;
		logic        found;
		res   = a;
		found = 1'b0;
		for (int k = 1; k <= LCM_SEARCH; k++) begin
			m = 16'(a) * 16'(k);
			if (!found && (m % 16'(b)) == 16'h0000) begin
				res   = m[7:0];
				found = 1'b1;
			end
		end
		return res;
	endfunction : lcm2

endpackage : zdcc_pkg

/* File: hw/zdcc_divider.sv */
// Even ratio clock divider stepped by a shared tick
`timescale 1ns/100ps
module zdcc_divider (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     tick_i,
	input  wire logic                     restart_i,
	input  wire logic [zdcc_pkg::DIV_W-1:0] ratio_i,
	output logic                          clk_o
);
	logic [zdcc_pkg::DIV_W-1:0] cnt_ff;
	logic [zdcc_pkg::DIV_W-1:0] nxt_cnt;
	logic                       out_ff;
	logic                       nxt_out;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_out = out_ff;
		if (tick_i) begin
			if (restart_i || cnt_ff == ratio_i - 8'h01) begin
				nxt_cnt = '0;
			end else begin
				nxt_cnt = cnt_ff + 8'h01;
			end
			nxt_out = nxt_cnt < (ratio_i >> 1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
			out_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
		end
	end

	assign clk_o = out_ff;

endmodule : zdcc_divider

/* File: hw/zdcc_top.sv */
// Clock divider control core with Wishbone registers
`timescale 1ns/100ps
module zdcc_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [1:0]  differential_reference_in_i,
	input  wire logic        test_clock_in_first_i,
	input  wire logic        test_clock_in_second_i,
	input  wire logic        feedback_clock_in_i,
	input  wire logic        master_reset_output_enable_n_i,
	input  wire logic        serial_clock_i,
	input  wire logic        serial_enable_data_i,
	output logic [3:0]       bank_a_clocks_o,
	output logic [3:0]       bank_b_clocks_o,
	output logic [3:0]       bank_c_clocks_o,
	output logic             feedback_clock_out_o,
	output logic             sync_pulse_o
);
	localparam int NP = zdcc_pkg::NPIN;
	localparam int NO = zdcc_pkg::NOUT;
	localparam int DW = zdcc_pkg::DIV_W;

	// Pin synchronisers and edge history
	logic [NP-1:0] pin_s1_ff, pin_s2_ff, pin_d_ff;
	logic [NP-1:0] nxt_s1, nxt_s2, nxt_d;
	logic          hold;
	logic          sclk_rise;

	always_comb begin
		nxt_s1 = {serial_enable_data_i, serial_clock_i, master_reset_output_enable_n_i,
			feedback_clock_in_i, test_clock_in_second_i, test_clock_in_first_i,
			differential_reference_in_i};
		nxt_s2 = pin_s1_ff;
		nxt_d  = pin_s2_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_d_ff  <= '0;
		end else begin
			pin_s1_ff <= nxt_s1;
			pin_s2_ff <= nxt_s2;
			pin_d_ff  <= nxt_d;
		end
	end

	assign hold      = ~pin_s2_ff[zdcc_pkg::PIN_MR];
	assign sclk_rise = pin_s2_ff[zdcc_pkg::PIN_SCLK] & ~pin_d_ff[zdcc_pkg::PIN_SCLK];

	// Selected reference level from one pin sample
	function automatic logic ref_level(input logic [NP-1:0] p, input zdcc_pkg::zdcc_ctrl_t c);
		if (c.reference_select) begin
			return p[zdcc_pkg::PIN_REF_P] & ~p[zdcc_pkg::PIN_REF_N];
		end else begin
			return c.test_clock_select ? p[zdcc_pkg::PIN_T2] : p[zdcc_pkg::PIN_T1];
		end
	endfunction : ref_level

	// Enable vector per output from serial bits
	function automatic logic [NO-1:0] en_map(input logic [zdcc_pkg::SER_N-1:0] m);
		return {m[11], 1'b1, m[10:8], 1'b1, m[7:0]};
	endfunction : en_map

	// Wishbone slave
	zdcc_pkg::zdcc_ctrl_t ctrl_ff, nxt_ctrl;
	logic                 ack_ff, nxt_ack;
	logic [31:0]          dat_ff, nxt_dat;
	logic [31:0]          wr_word;
	logic                 req;

	// Serial receiver
	zdcc_pkg::zdcc_ser_state_t ser_state_ff, nxt_ser_state;
	logic [3:0]                ser_cnt_ff, nxt_ser_cnt;
	logic [zdcc_pkg::SER_N-1:0] ser_sh_ff, nxt_ser_sh, mask_ff, nxt_mask;
	logic [zdcc_pkg::SER_N-1:0] ser_word;

	// Timebase
	logic          half_ff, nxt_half;
	logic          lat_halve_ff, nxt_lat_halve;
	logic [DW-1:0] m_cnt_ff, nxt_m_cnt;
	logic [DW-1:0] ratio_ff [zdcc_pkg::NDIV];
	logic [DW-1:0] nxt_ratio [zdcc_pkg::NDIV];
	logic [DW-1:0] lall_ff, nxt_lall, lac_ff, nxt_lac, win_ff, nxt_win;
	logic [DW-1:0] sync_cnt_ff, nxt_sync_cnt;
	logic          sync_raw_ff, nxt_sync_raw;
	logic [DW-1:0] tbl [zdcc_pkg::NDIV];
	logic [DW-1:0] fast, lac_new;
	logic          ref_lvl, ref_prev, ref_rise, tick, wrap, core_rst;
	logic [zdcc_pkg::NDIV-1:0] div_raw;

	// Output gating
	logic [NO-1:0] en_ff, nxt_en, out_ff, nxt_out;
	logic [NO-1:0] raw, pol, lvl;

	assign req = wb_cyc_i & wb_stb_i;

	always_comb begin
		nxt_ack  = req & ~ack_ff;
		nxt_dat  = dat_ff;
		nxt_ctrl = ctrl_ff;
		wr_word  = 32'(ctrl_ff);
		if (wb_sel_i[0]) begin
			wr_word[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			wr_word[15:8] = wb_dat_i[15:8];
		end
		if (req && wb_we_i && ack_ff && wb_adr_i == zdcc_pkg::ADR_CTRL) begin
			nxt_ctrl = zdcc_pkg::zdcc_ctrl_t'(wr_word[zdcc_pkg::CTRL_W-1:0]);
		end
		if (req && !ack_ff) begin
			unique case (wb_adr_i)
				zdcc_pkg::ADR_CTRL: nxt_dat = 32'(ctrl_ff);
				zdcc_pkg::ADR_MASK: nxt_dat = 32'(mask_ff);
				zdcc_pkg::ADR_STAT: nxt_dat = {16'h0000, lall_ff, 5'h00, ser_state_ff == zdcc_pkg::SER_SHIFT,
					pin_s2_ff[zdcc_pkg::PIN_FBIN], pin_s2_ff[zdcc_pkg::PIN_MR]};
				default:            nxt_dat = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= zdcc_pkg::CTRL_RST;
			ack_ff  <= 1'b0;
			dat_ff  <= '0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			ack_ff  <= nxt_ack;
			dat_ff  <= nxt_dat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	assign ser_word = {pin_s2_ff[zdcc_pkg::PIN_SDAT], ser_sh_ff[zdcc_pkg::SER_N-1:1]};

	always_comb begin
		nxt_ser_state = ser_state_ff;
		nxt_ser_cnt   = ser_cnt_ff;
		nxt_ser_sh    = ser_sh_ff;
		nxt_mask      = mask_ff;
		if (hold) begin
			nxt_ser_state = zdcc_pkg::SER_IDLE;
			nxt_ser_cnt   = '0;
			nxt_mask      = zdcc_pkg::MASK_RST;
		end else if (sclk_rise) begin
			unique case (ser_state_ff)
				zdcc_pkg::SER_IDLE: begin
					if (!pin_s2_ff[zdcc_pkg::PIN_SDAT]) begin
						nxt_ser_state = zdcc_pkg::SER_SHIFT;
						nxt_ser_cnt   = '0;
					end
				end
				zdcc_pkg::SER_SHIFT: begin
					nxt_ser_sh  = ser_word;
					nxt_ser_cnt = ser_cnt_ff + 4'h1;
					if (ser_cnt_ff == zdcc_pkg::SER_LAST) begin
						nxt_mask      = ser_word;
						nxt_ser_state = zdcc_pkg::SER_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ser_state_ff <= zdcc_pkg::SER_IDLE;
			ser_cnt_ff   <= '0;
			ser_sh_ff    <= '0;
			mask_ff      <= zdcc_pkg::MASK_RST;
		end else begin
			ser_state_ff <= nxt_ser_state;
			ser_cnt_ff   <= nxt_ser_cnt;
			ser_sh_ff    <= nxt_ser_sh;
			mask_ff      <= nxt_mask;
		end
	end

	assign ref_lvl  = ref_level(pin_s2_ff, ctrl_ff);
	assign ref_prev = ref_level(pin_d_ff, ctrl_ff);
	assign ref_rise = ref_lvl & ~ref_prev;
	assign tick     = ctrl_ff.pll_enable ? (lat_halve_ff | half_ff) : ref_rise;
	assign wrap     = tick & (m_cnt_ff == lall_ff - 8'h01);
	assign core_rst = rst_i | hold;

	always_comb begin
		tbl[zdcc_pkg::DIV_A]  = zdcc_pkg::a_ratio(ctrl_ff.bank_a_divider_select);
		tbl[zdcc_pkg::DIV_B]  = zdcc_pkg::b_ratio(ctrl_ff.bank_b_divider_select);
		tbl[zdcc_pkg::DIV_C]  = zdcc_pkg::c_ratio(ctrl_ff.bank_c_divider_select);
		tbl[zdcc_pkg::DIV_FB] = zdcc_pkg::fb_ratio(ctrl_ff.feedback_multiplier_select);
		fast    = (tbl[zdcc_pkg::DIV_A] < tbl[zdcc_pkg::DIV_C]) ? tbl[zdcc_pkg::DIV_A] : tbl[zdcc_pkg::DIV_C];
		lac_new = zdcc_pkg::lcm2(tbl[zdcc_pkg::DIV_A], tbl[zdcc_pkg::DIV_C]);
		nxt_half      = ~half_ff;
		nxt_lat_halve = lat_halve_ff;
		nxt_m_cnt     = m_cnt_ff;
		nxt_ratio     = ratio_ff;
		nxt_lall      = lall_ff;
		nxt_lac       = lac_ff;
		nxt_win       = win_ff;
		nxt_sync_cnt  = sync_cnt_ff;
		nxt_sync_raw  = sync_raw_ff;
		if (hold || wrap) begin
			nxt_half      = 1'b0; // Full first period after a halve change
			nxt_ratio     = tbl;
			nxt_lat_halve = ctrl_ff.vco_halve_select;
			nxt_lall = zdcc_pkg::lcm2(zdcc_pkg::lcm2(lac_new, tbl[zdcc_pkg::DIV_B]), tbl[zdcc_pkg::DIV_FB]);
			nxt_lac  = lac_new;
			nxt_win  = (lac_new == fast) ? (fast >> 1) : fast;
		end
		if (hold) begin
			nxt_m_cnt    = '0;
			nxt_sync_cnt = '0;
			nxt_sync_raw = 1'b0;
		end else if (tick) begin
			nxt_m_cnt    = wrap ? '0 : m_cnt_ff + 8'h01;
			nxt_sync_cnt = (wrap || sync_cnt_ff == lac_ff - 8'h01) ? '0 : sync_cnt_ff + 8'h01;
			nxt_sync_raw = nxt_sync_cnt < (lac_ff - win_ff);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			half_ff      <= 1'b0;
			lat_halve_ff <= 1'b0;
			m_cnt_ff     <= '0;
			ratio_ff     <= '{default: zdcc_pkg::RATIO_RST};
			lall_ff      <= zdcc_pkg::RATIO_RST;
			lac_ff       <= zdcc_pkg::RATIO_RST;
			win_ff       <= zdcc_pkg::RATIO_RST;
			sync_cnt_ff  <= '0;
			sync_raw_ff  <= 1'b0;
		end else begin
			half_ff      <= nxt_half;
			lat_halve_ff <= nxt_lat_halve;
			m_cnt_ff     <= nxt_m_cnt;
			ratio_ff     <= nxt_ratio;
			lall_ff      <= nxt_lall;
			lac_ff       <= nxt_lac;
			win_ff       <= nxt_win;
			sync_cnt_ff  <= nxt_sync_cnt;
			sync_raw_ff  <= nxt_sync_raw;
		end
	end

	for (genvar g = 0; g < zdcc_pkg::NDIV; g++) begin : g_div
		zdcc_divider u_div (
			.clk_i     (clk_i),
			.rst_i     (core_rst),
			.tick_i    (tick),
			.restart_i (wrap),
			.ratio_i   (ratio_ff[g]),
			.clk_o     (div_raw[g])
		);
	end

	always_comb begin
		raw = {sync_raw_ff, div_raw[zdcc_pkg::DIV_FB], {zdcc_pkg::BANK_N{div_raw[zdcc_pkg::DIV_C]}},
			{zdcc_pkg::BANK_N{div_raw[zdcc_pkg::DIV_B]}}, {zdcc_pkg::BANK_N{div_raw[zdcc_pkg::DIV_A]}}};
		pol = '0;
		pol[zdcc_pkg::OUT_C2] = ctrl_ff.bank_c_invert_select;
		pol[zdcc_pkg::OUT_C3] = ctrl_ff.bank_c_invert_select;
		lvl = raw ^ pol;
		// Enable changes only while the level is low; hold sets every enable
		nxt_en  = hold ? '1 : ((lvl & en_ff) | (~lvl & en_map(mask_ff)));
		nxt_out = hold ? '0 : (nxt_en & lvl);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_ff  <= '1;
			out_ff <= '0;
		end else begin
			en_ff  <= nxt_en;
			out_ff <= nxt_out;
		end
	end

	assign bank_a_clocks_o      = out_ff[3:0];
	assign bank_b_clocks_o      = out_ff[7:4];
	assign bank_c_clocks_o      = out_ff[11:8];
	assign feedback_clock_out_o = out_ff[zdcc_pkg::OUT_FB];
	assign sync_pulse_o         = out_ff[zdcc_pkg::OUT_SYNC];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_load;
		ser_state_ff == zdcc_pkg::SER_SHIFT && sclk_rise && !hold && ser_cnt_ff == zdcc_pkg::SER_LAST;
	endsequence

	property p_hold_off;
		hold |=> out_ff == '0;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("outputs active in reset");

	property p_release;
		$fell(hold) && ctrl_ff.pll_enable |-> ##[1:8] feedback_clock_out_o;
	endproperty
	a_release: assert property (p_release) else $error("no feedback clock after release");

	property p_fb_tbl;
		hold |=> ratio_ff[zdcc_pkg::DIV_FB] == zdcc_pkg::fb_ratio($past(ctrl_ff.feedback_multiplier_select));
	endproperty
	a_fb_tbl: assert property (p_fb_tbl) else $error("feedback ratio wrong");

	property p_bank_tbl;
		hold |=> ratio_ff[zdcc_pkg::DIV_A] == zdcc_pkg::a_ratio($past(ctrl_ff.bank_a_divider_select))
			&& ratio_ff[zdcc_pkg::DIV_C] == zdcc_pkg::c_ratio($past(ctrl_ff.bank_c_divider_select));
	endproperty
	a_bank_tbl: assert property (p_bank_tbl) else $error("bank ratio wrong");

	property p_halve;
		(tick && !lat_halve_ff && ctrl_ff.pll_enable) |=> !(tick && !lat_halve_ff && ctrl_ff.pll_enable);
	endproperty
	a_halve: assert property (p_halve) else $error("halving stage missed");

	property p_bypass;
		!ctrl_ff.pll_enable && $rose(ref_lvl) && $stable(ctrl_ff) |-> tick;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass tick missing");

	property p_inv;
		ctrl_ff.bank_c_invert_select && !hold && en_ff[zdcc_pkg::OUT_C3] && $rose(div_raw[zdcc_pkg::DIV_C])
			|=> !out_ff[zdcc_pkg::OUT_C3];
	endproperty
	a_inv: assert property (p_inv) else $error("inversion missing");

	property p_gate;
		!en_ff[0] |=> !out_ff[0];
	endproperty
	a_gate: assert property (p_gate) else $error("disabled output toggled");

	property p_fb_free;
		!hold ##1 !hold |-> out_ff[zdcc_pkg::OUT_FB] == $past(div_raw[zdcc_pkg::DIV_FB]);
	endproperty
	a_fb_free: assert property (p_fb_free) else $error("feedback output stopped");

	property p_sync;
		$rose(sync_raw_ff) |-> $rose(div_raw[zdcc_pkg::DIV_A]) && $rose(div_raw[zdcc_pkg::DIV_C]);
	endproperty
	a_sync: assert property (p_sync) else $error("sync edge misaligned");

	property p_glitch;
		$changed(ratio_ff[zdcc_pkg::DIV_A]) |-> $past(wrap) || $past(hold);
	endproperty
	a_glitch: assert property (p_glitch) else $error("ratio changed mid period");

	property p_load;
		s_load |=> mask_ff == $past(ser_word) && ser_state_ff == zdcc_pkg::SER_IDLE;
	endproperty
	a_load: assert property (p_load) else $error("serial load wrong");

endmodule : zdcc_top

/* File: tb/zdcc_partner.sv */
// Board side model: reference sources, feedback loop and serial loader
`timescale 1ns/100ps
module zdcc_partner (
	input  wire logic  clk_i,
	input  wire logic  feedback_clock_out_i,
	output logic [1:0] diff_ref_o,
	output logic       tclk_first_o,
	output logic       tclk_second_o,
	output wire logic  feedback_clock_in_o,
	output logic       sclk_o,
	output logic       sdat_o
);
	int cnt = 0;
	assign feedback_clock_in_o = feedback_clock_out_i;
	initial begin
		diff_ref_o    = 2'h1;
		tclk_first_o  = 1'b0;
		tclk_second_o = 1'b0;
		sclk_o        = 1'b0;
		sdat_o        = 1'b1;
	end
	// Free running sources, periods 8, 10 and 14 cycles
	always @(posedge clk_i) begin
		cnt           <= cnt + 1;
		diff_ref_o    <= {cnt % 8 >= 4, cnt % 8 < 4};
		tclk_first_o  <= cnt % 10 < 5;
		tclk_second_o <= cnt % 14 < 7;
	end
	// Start bit, then D0 first; clock idles low, data idles high
	task automatic send(input logic [11:0] m);
		logic [12:0] f;
		f = {m, 1'b0};
		for (int i = 0; i < 13; i++) begin
			@(posedge clk_i);
			sdat_o <= f[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		sdat_o <= 1'b1;
	endtask : send
endmodule : zdcc_partner

/* File: tb/tb_top.sv */
// Self-checking bench for the clock divider control core
`timescale 1ns/100ps
module tb_top;
	localparam int TBL [4][8] = '{'{4, 6, 8, 12, 0, 0, 0, 0}, '{4, 6, 8, 10, 0, 0, 0, 0},
		'{2, 4, 6, 8, 0, 0, 0, 0}, '{4, 6, 8, 10, 8, 12, 16, 20}};
	logic        clk_i     = 1'b0;
	logic        rst_i     = 1'b1;
	logic        cyc       = 1'b0;
	logic        we        = 1'b0;
	logic [7:0]  adr       = 8'h00;
	logic [31:0] wdat      = 32'h0;
	logic        mr_n      = 1'b1;
	logic [31:0] seed      = 32'h3C;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [1:0]  dref;
	logic        t1, t2, fbi, fbo, sclk, sdat, sync;
	logic [3:0]  qa, qb, qc;
	logic [13:0] outs_q;
	int          err_total = 0;
	int          compares  = 0;
	wire  [13:0] outs      = {sync, fbo, qc, qb, qa};
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) outs_q <= outs;
	zdcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.differential_reference_in_i(dref), .test_clock_in_first_i(t1), .test_clock_in_second_i(t2),
		.feedback_clock_in_i(fbi), .master_reset_output_enable_n_i(mr_n), .serial_clock_i(sclk),
		.serial_enable_data_i(sdat), .bank_a_clocks_o(qa), .bank_b_clocks_o(qb), .bank_c_clocks_o(qc),
		.feedback_clock_out_o(fbo), .sync_pulse_o(sync));
	zdcc_partner u_partner (.clk_i(clk_i), .feedback_clock_out_i(fbo), .diff_ref_o(dref), .tclk_first_o(t1),
		.tclk_second_o(t2), .feedback_clock_in_o(fbi), .sclk_o(sclk), .sdat_o(sdat));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic results();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	task automatic fail();
		err_total++;
		$display("[FAIL] %0t wait ran out", $time);
		results();
	endtask : fail
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 50) fail();
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
	endtask : wb
	task automatic rise(input int j, output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
			if (n > 2000) fail();
		end while (!(outs_q[j] === 1'b0 && outs[j] === 1'b1));
	endtask : rise
	task automatic per(input int j, output int p);
		int n;
		rise(j, n);
		rise(j, p);
	endtask : per
	initial begin
		logic [31:0] q, c;
		logic [13:0] hi;
		logic [11:0] m;
		logic        bad;
		int          p, n, hv, old_a, nw;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		wb(1'b0, zdcc_pkg::ADR_CTRL, 32'h0, q);
		check(q, 32'h3FFF);
		wb(1'b1, 8'h10, 32'h0, q);
		wb(1'b1, zdcc_pkg::ADR_MASK, 32'h0, q);
		wb(1'b0, 8'h10, 32'h0, q);
		check(q, 32'h0);
		wb(1'b0, zdcc_pkg::ADR_MASK, 32'h0, q);
		check(q, 32'hFFF);
		wb(1'b0, zdcc_pkg::ADR_STAT, 32'h0, q);
		check(q & 32'hFFFFFFFD, 32'h00007801);
		$display("test registers done");
		old_a = 12;
		for (int i = 0; i < 8; i++) begin
			c = ((i == 0) ? 32'h1FF0 : (i == 1) ? 32'h8 : xs()) & 32'h1FF8 | 32'h3;
			hv = c[3] ? 1 : 2;
			nw = TBL[0][c[8:7]] * hv;
			wb(1'b1, zdcc_pkg::ADR_CTRL, c, q);
			rise(0, n);
			for (int k = 0; k < 12; k++) begin
				rise(0, p);
				check(32'((p - old_a) * (p - nw) <= 0), 32'h1);
			end
			repeat (500) @(posedge clk_i);
			for (int j = 0; j < 4; j++) begin
				per(j * 4, p);
				check(32'(p), 32'(TBL[j][j == 3 ? c[6:4] : (c >> (7 + 2 * j)) & 3] * hv));
			end
			old_a = nw;
		end
		$display("test ratios done");
		for (int k = 0; k < 3; k++) begin
			wb(1'b1, zdcc_pkg::ADR_CTRL, {19'h0, 13'h8 | 13'(k == 0) << 1 | 13'(k == 2) << 2}, q);
			repeat (k == 0 ? 2100 : 300) @(posedge clk_i);
			per(8, p);
			check(32'(p), 32'(k == 0 ? 16 : k == 1 ? 20 : 28));
		end
		$display("test references done");
		wb(1'b1, zdcc_pkg::ADR_CTRL, 32'h288B, q);
		repeat (300) @(posedge clk_i);
		rise(13, n);
		check(32'({outs_q[0], outs[0], outs_q[8], outs[8]}), 32'h5);
		per(13, p);
		check(32'(p), 32'hC);
		bad = 1'b0;
		repeat (40) begin
			@(posedge clk_i);
			#1;
			bad |= (qc[2] !== ~qc[1]) | (qc[3] !== ~qc[1]);
		end
		check(32'(bad), 32'h0);
		$display("test sync and invert done");
		for (int i = 0; i < 2; i++) begin
			m = i ? 12'h000 : 12'(xs());
			u_partner.send(m);
			repeat (50) @(posedge clk_i);
			wb(1'b0, zdcc_pkg::ADR_MASK, 32'h0, q);
			check(q, {20'h0, m});
			hi = 14'h0;
			repeat (100) begin
				@(posedge clk_i);
				#1;
				hi |= outs;
			end
			check(32'(hi), 32'({m[11], 1'b1, m[10:8], 1'b1, m[7:0]}));
		end
		$display("test serial enables done");
		@(posedge clk_i);
		mr_n <= 1'b0;
		repeat (5) @(posedge clk_i);
		hi = 14'h0;
		repeat (20) begin
			@(posedge clk_i);
			#1;
			hi |= outs;
		end
		check(32'(hi), 32'h0);
		wb(1'b0, zdcc_pkg::ADR_MASK, 32'h0, q);
		check(q, 32'hFFF);
		mr_n <= 1'b1;
		repeat (100) @(posedge clk_i);
		per(0, p);
		check(32'(p), 32'h6);
		$display("test pin reset done");
		results();
	end
endmodule : tb_top
